// File: pcit_defines.svh
`ifndef PCIT_DEFINES_SVH
`define PCIT_DEFINES_SVH
// ==========================================================
// Bus commands and decode
`define PCIT_CMD_IO_RD 4'h2
`define PCIT_CMD_IO_WR 4'h3
`define PCIT_CMD_MEM_RD 4'h6
`define PCIT_CMD_MEM_WR 4'h7
`define PCIT_CMD_CFG_RD 4'ha
`define PCIT_CMD_CFG_WR 4'hb
`define PCIT_BAR_MASK 32'hffff_ff00
`define PCIT_BAR_BASE 32'h0000_1000
`define PCIT_WORD_IDX_LSB 2
`define PCIT_WORD_IDX_MSB 5
`define PCIT_MEM_DEPTH 16
`define PCIT_ALL_ONES 32'hffff_ffff
`endif

// File: pcit_pkg.sv
package pcit_pkg;
	typedef enum logic [5:0] {
		PCIT_IDLE = 6'h01,
		PCIT_DECODE = 6'h02,
		PCIT_DATA = 6'h04,
		PCIT_TURN = 6'h08,
		PCIT_BUSY = 6'h10,
		PCIT_DONE = 6'h20
	} pcit_state_e;
	typedef enum logic [4:0] {
		PCIM_IDLE = 5'h01,
		PCIM_ADDR = 5'h02,
		PCIM_DATA = 5'h04,
		PCIM_LAST = 5'h08,
		PCIM_TURN = 5'h10
	} pcim_state_e;

	function automatic logic pcit_even_par(input logic [31:0] ad, input logic [3:0] cbe);
		pcit_even_par = ^{ad, cbe};
	endfunction
endpackage

// File: pcit_bus_if.sv
interface pcit_bus_if;
	logic [31:0] ad_m;
	logic ad_m_oe;
	logic [31:0] ad_t;
	logic ad_t_oe;
	logic [3:0] cbe_n;
	logic par_m;
	logic par_m_oe;
	logic par_t;
	logic par_t_oe;
	logic frame_n;
	logic irdy_n;
	logic idsel;
	logic trdy_n;
	logic trdy_oe;
	logic stop_n;
	logic stop_oe;
	logic devsel_n;
	logic devsel_oe;
	logic perr_n;
	logic perr_oe;
	logic inta_oe;
	wire [31:0] ad = ad_t_oe ? ad_t : (ad_m_oe ? ad_m : 32'h0000_0000);
	wire par = par_t_oe ? par_t : (par_m_oe ? par_m : 1'b0);
	wire trdy_w = trdy_oe ? trdy_n : 1'b1;
	wire stop_w = stop_oe ? stop_n : 1'b1;
	wire devsel_w = devsel_oe ? devsel_n : 1'b1;
	wire perr_w = perr_oe ? perr_n : 1'b1;
	wire inta_w = !inta_oe;
	modport target(input ad_m, ad_m_oe, cbe_n, par_m, frame_n, irdy_n, idsel, ad, par,
		output ad_t, ad_t_oe, par_t, par_t_oe, trdy_n, trdy_oe, stop_n, stop_oe,
		devsel_n, devsel_oe, perr_n, perr_oe, inta_oe);
	modport master(input ad_t, ad_t_oe, par_t, par_t_oe, trdy_w, stop_w, devsel_w,
		perr_w, inta_w, ad, par,
		output ad_m, ad_m_oe, cbe_n, par_m, par_m_oe, frame_n, irdy_n, idsel);
endinterface

// File: pcit_target.sv
`include "pcit_defines.svh"
module pcit_target (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	pcit_bus_if.target bus,
	input wire logic external_interrupt_input_zero_i,
	input wire logic external_interrupt_input_one_i,
	input wire logic [1:0] irq_mask_i,
	input wire logic irq_clear_i,
	output logic [1:0] irq_pending_o,
	output logic [31:0] cfg_word_o
);
	// ==========================================================
	// Reset release sync
	logic rst_s1_q, rst_s2_q;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	wire rst_n = rst_s2_q;

	// ==========================================================
	// External interrupt inputs; pins are asynchronous, so two flops first
	logic [1:0] xi_s1_q, xi_s2_q, xi_s3_q, irq_q, irq_d;
	always_comb begin
		irq_d = irq_q | (xi_s2_q ^ xi_s3_q);
		if (irq_clear_i)
			irq_d = xi_s2_q ^ xi_s3_q; // Set wins over clear
	end
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			xi_s1_q <= 2'h0;
			xi_s2_q <= 2'h0;
			xi_s3_q <= 2'h0;
			irq_q <= 2'h0;
		end else begin
			xi_s1_q <= {external_interrupt_input_one_i, external_interrupt_input_zero_i};
			xi_s2_q <= xi_s1_q;
			xi_s3_q <= xi_s2_q;
			irq_q <= irq_d;
		end
	end
	assign irq_pending_o = irq_q;
	assign bus.inta_oe = |(irq_q & irq_mask_i);

	// ==========================================================
	// Target state machine
	pcit_pkg::pcit_state_e st_q, st_d;
	logic [31:0] mem_q [`PCIT_MEM_DEPTH];
	logic [31:0] cfg_q, cfg_d, rdat_q, rdat_d;
	logic [3:0] idx_q, idx_d, cmd_q, cmd_d;
	logic is_cfg_q, is_cfg_d, rd_q, rd_d, devsel_q, devsel_d, trdy_q, trdy_d;
	logic stop_q, stop_d, oe_q, oe_d, par_q, par_d, par_oe_q, par_oe_d;
	logic chk_q, chk_d, perr_q, perr_d, perr_oe_q, perr_oe_d;
	logic [31:0] wdat_q, wdat_d;
	logic [3:0] wbe_q, wbe_d;
	logic wr_q, wr_d;
	logic hit;
	logic xfer;

	always_comb begin
		// Only memory/io read/write and config cycles are claimed; master cmds never issued
		hit = ((bus.cbe_n == `PCIT_CMD_CFG_RD || bus.cbe_n == `PCIT_CMD_CFG_WR) && bus.idsel)
			|| ((bus.cbe_n == `PCIT_CMD_MEM_RD || bus.cbe_n == `PCIT_CMD_MEM_WR
			|| bus.cbe_n == `PCIT_CMD_IO_RD || bus.cbe_n == `PCIT_CMD_IO_WR)
			&& ((bus.ad & `PCIT_BAR_MASK) == `PCIT_BAR_BASE));
		xfer = !bus.irdy_n && trdy_q;
		st_d = st_q;
		idx_d = idx_q;
		cmd_d = cmd_q;
		is_cfg_d = is_cfg_q;
		rd_d = rd_q;
		devsel_d = devsel_q;
		trdy_d = 1'b0;
		stop_d = stop_q;
		oe_d = oe_q;
		rdat_d = rdat_q;
		cfg_d = cfg_q;
		wdat_d = wdat_q;
		wbe_d = wbe_q;
		wr_d = 1'b0;
		chk_d = 1'b0;
		par_d = pcit_pkg::pcit_even_par(rdat_q, bus.cbe_n);
		par_oe_d = oe_q && rd_q && xfer;
		perr_d = !(chk_q && (pcit_pkg::pcit_even_par(wdat_q, wbe_q) != bus.par));
		perr_oe_d = chk_q || (perr_oe_q && !perr_d);
		unique case (st_q)
			pcit_pkg::PCIT_IDLE: begin
				if (!bus.frame_n) begin
					st_d = hit ? pcit_pkg::PCIT_DECODE : pcit_pkg::PCIT_BUSY;
					idx_d = bus.ad[`PCIT_WORD_IDX_MSB:`PCIT_WORD_IDX_LSB];
					cmd_d = bus.cbe_n;
					is_cfg_d = bus.idsel && (bus.cbe_n == `PCIT_CMD_CFG_RD
						|| bus.cbe_n == `PCIT_CMD_CFG_WR);
					rd_d = !bus.cbe_n[0];
				end
			end
			pcit_pkg::PCIT_DECODE: begin
				devsel_d = 1'b1;
				oe_d = 1'b1;
				rdat_d = is_cfg_q ? cfg_q : mem_q[idx_q];
				trdy_d = 1'b1; // Ready next cycle: data is always at hand
				st_d = pcit_pkg::PCIT_DATA;
			end
			pcit_pkg::PCIT_DATA: begin
				trdy_d = 1'b1;
				if (xfer) begin
					if (!rd_q) begin
						wdat_d = bus.ad;
						wbe_d = bus.cbe_n;
						wr_d = 1'b1;
						chk_d = 1'b1;
					end
					// Single data phase only; bursts are cut by stop
					if (!bus.frame_n) begin
						stop_d = 1'b1;
						trdy_d = 1'b0;
						st_d = pcit_pkg::PCIT_DONE;
					end else begin
						trdy_d = 1'b0;
						st_d = pcit_pkg::PCIT_TURN;
					end
				end
			end
			pcit_pkg::PCIT_DONE: begin
				if (bus.frame_n) begin
					stop_d = 1'b0;
					st_d = pcit_pkg::PCIT_TURN;
				end
			end
			pcit_pkg::PCIT_TURN: begin
				// Devsel deasserts and the drivers float on the same edge (turnaround)
				devsel_d = 1'b0;
				oe_d = 1'b0;
				st_d = pcit_pkg::PCIT_IDLE;
			end
			pcit_pkg::PCIT_BUSY: begin
				if (bus.frame_n && bus.irdy_n)
					st_d = pcit_pkg::PCIT_IDLE;
			end
			default: st_d = pcit_pkg::PCIT_IDLE;
		endcase
		if (wr_q && is_cfg_q)
			cfg_d = wdat_q;
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= pcit_pkg::PCIT_IDLE;
			idx_q <= 4'h0;
			cmd_q <= 4'h0;
			is_cfg_q <= 1'b0;
			rd_q <= 1'b0;
			devsel_q <= 1'b0;
			trdy_q <= 1'b0;
			stop_q <= 1'b0;
			oe_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
			cfg_q <= 32'h0000_0000;
			wdat_q <= 32'h0000_0000;
			wbe_q <= 4'hf;
			wr_q <= 1'b0;
			chk_q <= 1'b0;
			par_q <= 1'b0;
			par_oe_q <= 1'b0;
			perr_q <= 1'b1;
			perr_oe_q <= 1'b0;
		end else begin
			st_q <= st_d;
			idx_q <= idx_d;
			cmd_q <= cmd_d;
			is_cfg_q <= is_cfg_d;
			rd_q <= rd_d;
			devsel_q <= devsel_d;
			trdy_q <= trdy_d;
			stop_q <= stop_d;
			oe_q <= oe_d;
			rdat_q <= rdat_d;
			cfg_q <= cfg_d;
			wdat_q <= wdat_d;
			wbe_q <= wbe_d;
			wr_q <= wr_d;
			chk_q <= chk_d;
			par_q <= par_d;
			par_oe_q <= par_oe_d;
			perr_q <= perr_d;
			perr_oe_q <= perr_oe_d;
		end
	end

	// ==========================================================
	// Memory words, byte lanes honoured; no reset to keep it flop-cheap
	always_ff @(posedge core_clk_i) begin
		if (wr_q && !is_cfg_q) begin
			for (int b = 0; b < 4; b++) begin
				if (!wbe_q[b])
					mem_q[idx_q][b*8 +: 8] <= wdat_q[b*8 +: 8];
			end
		end
	end

	assign cfg_word_o = cfg_q;
	assign bus.devsel_n = !devsel_q;
	assign bus.devsel_oe = oe_q;
	assign bus.trdy_n = !trdy_q;
	assign bus.trdy_oe = oe_q;
	assign bus.stop_n = !stop_q;
	assign bus.stop_oe = oe_q;
	assign bus.ad_t = rdat_q;
	assign bus.ad_t_oe = oe_q && rd_q && st_q == pcit_pkg::PCIT_DATA;
	assign bus.par_t = par_q;
	assign bus.par_t_oe = par_oe_q;
	assign bus.perr_n = perr_q;
	assign bus.perr_oe = perr_oe_q;
endmodule // pcit_target

// File: pcit_master.sv
`include "pcit_defines.svh"
module pcit_master (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	pcit_bus_if.master bus,
	input wire logic req_valid_i,
	input wire logic [3:0] req_cmd_i,
	input wire logic [31:0] req_addr_i,
	input wire logic [31:0] req_wdata_i,
	input wire logic [3:0] req_be_n_i,
	input wire logic req_idsel_i,
	output logic req_ready_o,
	output logic rsp_valid_o,
	output logic [31:0] rsp_rdata_o,
	output logic rsp_abort_o,
	output logic irq_o
);
	// ==========================================================
	// Master sequencer, single data phase
	pcit_pkg::pcim_state_e st_q, st_d;
	logic [31:0] ad_q, ad_d, rd_q, rd_d;
	logic [3:0] cbe_q, cbe_d;
	logic [31:0] wd_q, wd_d;
	logic [3:0] be_q, be_d;
	logic frame_q, frame_d, irdy_q, irdy_d, idsel_q, idsel_d, aoe_q, aoe_d, rdc_q, rdc_d;
	logic par_q, par_d, poe_q, poe_d, rv_q, rv_d, ab_q, ab_d;
	logic [2:0] wait_q, wait_d;

	always_comb begin
		st_d = st_q;
		ad_d = ad_q;
		cbe_d = cbe_q;
		wd_d = wd_q;
		be_d = be_q;
		frame_d = frame_q;
		irdy_d = irdy_q;
		idsel_d = 1'b0;
		aoe_d = aoe_q;
		rdc_d = rdc_q;
		rd_d = rd_q;
		rv_d = 1'b0;
		ab_d = 1'b0;
		wait_d = wait_q;
		// Parity lags the data it covers by one clock
		par_d = pcit_pkg::pcit_even_par(ad_q, cbe_q);
		poe_d = aoe_q;
		unique case (st_q)
			pcit_pkg::PCIM_IDLE: begin
				if (req_valid_i) begin
					frame_d = 1'b1;
					ad_d = req_addr_i;
					cbe_d = req_cmd_i;
					wd_d = req_wdata_i;
					be_d = req_be_n_i;
					idsel_d = req_idsel_i;
					rdc_d = !req_cmd_i[0];
					aoe_d = 1'b1;
					wait_d = 3'h0;
					st_d = pcit_pkg::PCIM_ADDR;
				end
			end
			pcit_pkg::PCIM_ADDR: begin
				frame_d = 1'b0; // Single phase: last data phase at once
				irdy_d = 1'b1;
				cbe_d = be_q;
				ad_d = wd_q;
				aoe_d = !rdc_q; // Read turnaround frees AD for target
				st_d = pcit_pkg::PCIM_DATA;
			end
			pcit_pkg::PCIM_DATA: begin
				wait_d = wait_q + 3'h1;
				if (!bus.trdy_w || !bus.stop_w) begin
					rd_d = bus.ad;
					rv_d = 1'b1;
					ab_d = bus.trdy_w;
					st_d = pcit_pkg::PCIM_TURN;
					irdy_d = 1'b0;
					aoe_d = 1'b0;
				end else if (wait_q == 3'h7 && bus.devsel_w) begin
					// Nobody claimed it: master abort
					rv_d = 1'b1;
					ab_d = 1'b1;
					irdy_d = 1'b0;
					aoe_d = 1'b0;
					st_d = pcit_pkg::PCIM_TURN;
				end
			end
			pcit_pkg::PCIM_TURN: st_d = pcit_pkg::PCIM_IDLE;
			default: st_d = pcit_pkg::PCIM_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= pcit_pkg::PCIM_IDLE;
			ad_q <= 32'h0000_0000;
			cbe_q <= 4'hf;
			wd_q <= 32'h0000_0000;
			be_q <= 4'hf;
			frame_q <= 1'b0;
			irdy_q <= 1'b0;
			idsel_q <= 1'b0;
			aoe_q <= 1'b0;
			rdc_q <= 1'b0;
			rd_q <= 32'h0000_0000;
			par_q <= 1'b0;
			poe_q <= 1'b0;
			rv_q <= 1'b0;
			ab_q <= 1'b0;
			wait_q <= 3'h0;
		end else begin
			st_q <= st_d;
			ad_q <= ad_d;
			cbe_q <= cbe_d;
			wd_q <= wd_d;
			be_q <= be_d;
			frame_q <= frame_d;
			irdy_q <= irdy_d;
			idsel_q <= idsel_d;
			aoe_q <= aoe_d;
			rdc_q <= rdc_d;
			rd_q <= rd_d;
			par_q <= par_d;
			poe_q <= poe_d;
			rv_q <= rv_d;
			ab_q <= ab_d;
			wait_q <= wait_d;
		end
	end

	assign bus.ad_m = ad_q;
	assign bus.ad_m_oe = aoe_q;
	assign bus.cbe_n = cbe_q;
	assign bus.par_m = par_q;
	assign bus.par_m_oe = poe_q;
	assign bus.frame_n = !frame_q;
	assign bus.irdy_n = !irdy_q;
	assign bus.idsel = idsel_q;
	assign req_ready_o = st_q == pcit_pkg::PCIM_IDLE;
	assign rsp_valid_o = rv_q;
	assign rsp_rdata_o = rd_q;
	assign rsp_abort_o = ab_q;
	assign irq_o = !bus.inta_w;
endmodule // pcit_master

// File: pcit_bus_assertions.sv
module pcit_bus_assertions (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [31:0] ad,
	input wire logic [3:0] cbe_n,
	input wire logic par,
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic idsel,
	input wire logic trdy_n,
	input wire logic trdy_oe,
	input wire logic stop_oe,
	input wire logic devsel_n,
	input wire logic devsel_oe,
	input wire logic perr_n,
	input wire logic perr_oe,
	input wire logic ad_t_oe,
	input wire logic ad_m_oe,
	input wire logic par_t_oe,
	input wire logic par_m_oe
);
	// ==========================================
	// Helpers
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	logic hit;
	logic xfer;
	logic bad;
	logic [35:0] prev_q;
	// Memory space at 0x1000 or config with select
	assign hit = (cbe_n[3:1] == 3'h3 && ad[31:8] == 24'h000010) || (idsel && cbe_n[3:1] == 3'h5);
	assign xfer = !irdy_n && trdy_oe && !trdy_n;
	// Parity lags its data cycle by one
	always_ff @(posedge core_clk_i) prev_q <= {ad, cbe_n};
	assign bad = par_m_oe && (par != ^prev_q);
	sequence s_start;
		$fell(frame_n) && hit;
	endsequence
	sequence s_claim;
		devsel_oe && !devsel_n;
	endsequence
	// ==========================================
	// Properties
	a_claim_own: assert property (s_start |-> ##[2:3] s_claim)
		else $error("own access not claimed");
	a_miss_quiet: assert property ($fell(frame_n) && !hit |-> ##1 (!devsel_oe) [*4])
		else $error("foreign access claimed");
	a_trdy_sel: assert property (trdy_oe && !trdy_n |-> s_claim)
		else $error("ready without select");
	a_float_free: assert property (!devsel_oe |-> !trdy_oe && !stop_oe && !ad_t_oe)
		else $error("driving while unselected");
	a_one_beat: assert property (xfer |=> !(trdy_oe && !trdy_n))
		else $error("ready held after phase");
	a_trdy_hold: assert property (trdy_oe && !trdy_n && irdy_n |=> trdy_oe && !trdy_n)
		else $error("ready dropped early");
	a_bus_release: assert property (xfer |-> ##[1:2] !devsel_oe)
		else $error("select not released");
	a_par_even: assert property (($past(ad_m_oe) || $past(ad_t_oe)) && (par_m_oe || par_t_oe)
		|-> par == ^prev_q)
		else $error("parity not even");
	a_perr_cause: assert property (perr_oe && !perr_n |-> $past(bad) || $past(bad, 2))
		else $error("parity error without cause");
endmodule // pcit_bus_assertions

// File: pci_target_interface_test.sv
`include "pcit_defines.svh"
module pci_target_interface_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_i, rst_n_i, req_valid, idsel, ext0, ext1, clr;
	logic ready, rsp_valid, abort, irq, ab;
	logic [3:0] cmd, be_n;
	logic [1:0] mask, pending;
	logic [31:0] addr, wdata, rdata, rd, cfg_word, mdl_cfg, rv;
	logic [31:0] mdl [16];
	int miscompares, total_checks;
	pcit_bus_if bus ();
	pcit_master i_pcit_master (.core_clk_i, .rst_n_i, .bus(bus.master), .req_valid_i(req_valid),
		.req_cmd_i(cmd), .req_addr_i(addr), .req_wdata_i(wdata), .req_be_n_i(be_n),
		.req_idsel_i(idsel), .req_ready_o(ready), .rsp_valid_o(rsp_valid),
		.rsp_rdata_o(rdata), .rsp_abort_o(abort), .irq_o(irq));
	pcit_target i_pcit_target (.core_clk_i, .rst_n_i, .bus(bus.target),
		.external_interrupt_input_zero_i(ext0), .external_interrupt_input_one_i(ext1),
		.irq_mask_i(mask), .irq_clear_i(clr), .irq_pending_o(pending), .cfg_word_o(cfg_word));
	pcit_bus_assertions u_chk (.core_clk_i, .rst_n_i, .ad(bus.ad), .cbe_n(bus.cbe_n),
		.par(bus.par), .frame_n(bus.frame_n), .irdy_n(bus.irdy_n), .idsel(bus.idsel),
		.trdy_n(bus.trdy_n), .trdy_oe(bus.trdy_oe), .stop_oe(bus.stop_oe),
		.devsel_n(bus.devsel_n), .devsel_oe(bus.devsel_oe), .perr_n(bus.perr_n),
		.perr_oe(bus.perr_oe), .ad_t_oe(bus.ad_t_oe), .ad_m_oe(bus.ad_m_oe),
		.par_t_oe(bus.par_t_oe), .par_m_oe(bus.par_m_oe));
	// ==========================================
	// Tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results();
		if (miscompares == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Request held until taken, then one response pulse
	task automatic xact(input logic [3:0] c, input logic [31:0] a, d, input logic [3:0] b,
		input logic s);
		int n;
		@(negedge core_clk_i);
		{req_valid, cmd, addr, wdata, be_n, idsel} = {1'b1, c, a, d, b, s};
		for (n = 0; !ready && n < 50; n++) @(negedge core_clk_i);
		@(negedge core_clk_i);
		req_valid = 1'b0;
		for (n = 0; !rsp_valid && n < 50; n++) @(negedge core_clk_i);
		chk(32'(rsp_valid), 32'h1);
		rd = rdata;
		ab = abort;
	endtask
	task automatic mem_op(input logic wr, input int i, input logic [3:0] b);
		logic [31:0] d;
		d = $urandom;
		xact(wr ? `PCIT_CMD_MEM_WR : `PCIT_CMD_MEM_RD, `PCIT_BAR_BASE + 32'(i) * 4, d, b, 1'b0);
		chk(32'(ab), 32'h0);
		if (wr) begin
			for (int n = 0; n < 4; n++) if (!b[n]) mdl[i][8*n +: 8] = d[8*n +: 8];
			// Parity report lands after the turnaround edge
			@(negedge core_clk_i);
			chk(32'(bus.perr_w), 32'h1);
		end else
			chk(rd, mdl[i]);
	endtask
	task automatic irq_chk(input logic [1:0] p);
		repeat (8) @(negedge core_clk_i);
		chk(32'(pending), 32'(p));
		chk(32'(bus.inta_w), 32'((p & mask) == 2'h0));
	endtask
	task automatic pulse_clr();
		clr = 1'b1;
		@(negedge core_clk_i);
		clr = 1'b0;
	endtask
	// ==========================================
	// Run
	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end
	initial begin
		#40us;
		miscompares++;
		results();
	end
	initial begin
		{rst_n_i, req_valid, idsel, ext0, ext1, clr, cmd, be_n, mask, addr, wdata} = '0;
		rv = $urandom(32'h14cd);
		repeat (4) @(negedge core_clk_i);
		rst_n_i = 1'b1;
		// Synchroniser needs a few edges before the target listens
		repeat (4) @(negedge core_clk_i);
		for (int i = 0; i < 16; i++) mem_op(1'b1, i, 4'h0);
		repeat (60) mem_op(1'($urandom), int'($urandom_range(15)), 4'($urandom));
		rv = $urandom;
		xact(`PCIT_CMD_CFG_WR, 32'h0, rv, 4'h0, 1'b1);
		mdl_cfg = rv;
		// Config word is stored on the edge after the response pulse
		@(negedge core_clk_i);
		chk(cfg_word, mdl_cfg);
		xact(`PCIT_CMD_CFG_RD, 32'h0, 32'h0, 4'h0, 1'b1);
		chk(rd, mdl_cfg);
		xact(`PCIT_CMD_CFG_WR, 32'h0, ~rv, 4'h0, 1'b0);
		chk(32'(ab), 32'h1);
		chk(cfg_word, mdl_cfg);
		xact(`PCIT_CMD_MEM_RD, 32'h2000, 32'h0, 4'h0, 1'b0);
		chk(32'(ab), 32'h1);
		ext0 = 1'b1;
		irq_chk(2'h1);
		mask = 2'h1;
		irq_chk(2'h1);
		chk(32'(irq), 32'h1);
		pulse_clr();
		irq_chk(2'h0);
		mask = 2'h2;
		ext1 = 1'b1;
		irq_chk(2'h2);
		pulse_clr();
		irq_chk(2'h0);
		ext1 = 1'b0;
		irq_chk(2'h2);
		results();
	end
endmodule // pci_target_interface_test
